// >>> gpx_pkg.sv
// Purpose: Constants and carrier types for the 8-pin I/O port with external interrupts
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Functional notes below are referenced by the design as see RQn
//
// Functional notes
// RQ1: Bit X of direction, option and value registers controls pin X only.
// RQ2: Direction clear makes an input; value read returns the live pin level.
// RQ3: Writing the value latch of an input pin never changes the pin.
// RQ4: Direction set drives the latch out; value read returns the latch.
// RQ5: Option picks push-pull or open-drain; zero drives low, one floats in open-drain.
// RQ6: Each interrupt-input pin can raise an external request on its own.
// RQ7: Pin events are qualified by vector sensitivity, then ORed into that vector.
// RQ8: Request latch is hidden from software and clears on vector fetch.
// RQ9: Rewriting a vector's sensitivity discards its pending request; the code discards it only when the written value differs.
// RQ10: An enabled peripheral function overrides direction, option and latch.
// RQ11: Peripheral outputs force output mode, push-pull or open-drain per peripheral.
// RQ12: Peripheral inputs need input mode; value read still returns the pin.
// RQ13: Input pin driven by peripheral output reads back the peripheral value.
// RQ14: Output pin feeding a peripheral input gives it the latch value.
// RQ15: Interrupt only in interrupt-input mode and with CPU mask inactive.
// RQ16: Low-power modes leave pins alone; external requests wake the device.
// RQ17: Standard pins: 00 float, 01 pull-up, 10 open-drain, 11 push-pull.
// RQ18: Pull-up interrupt pins: 01 is pull-up input with interrupt.
// RQ19: Software writes the latch before switching a pin to output.
// RQ20: Software avoids bit set or clear instructions on the value register.
// RQ21: Software keeps peripheral functions off interrupt-input pins.
// RQ22: Pins used both ways by a peripheral are set as floating input.
// RQ23: Floating interrupt pins: 01 is floating input with interrupt.
// RQ24: Vector request stays set from first event until fetch or rewrite; the code ignores a rewrite that keeps the same sensitivity value.

package gpx_pkg;

    localparam int unsigned NUM_PINS = 8;
    localparam int unsigned NUM_VEC  = 2;

    // Register byte offsets
    localparam logic [7:0] OFF_VALUE = 8'h00;
    localparam logic [7:0] OFF_DIR   = 8'h04;
    localparam logic [7:0] OFF_OPT   = 8'h08;
    localparam logic [7:0] OFF_SENS  = 8'h0c;
    localparam logic [7:0] OFF_STAT  = 8'h10;

    // Values after reset
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'h00;
    localparam logic [7:0] RST_OPT   = 8'h00;
    localparam logic [3:0] RST_SENS  = 4'h0;

    // Sensitivity field: two bits per vector, vector v at bits 2v+1:2v
    localparam int unsigned SENS_W   = 2;
    localparam logic [1:0] SENS_LOW  = 2'h0;
    localparam logic [1:0] SENS_RISE = 2'h1;
    localparam logic [1:0] SENS_FALL = 2'h2;
    localparam logic [1:0] SENS_BOTH = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Peripheral side of the pins
    typedef struct packed {
        logic [7:0] out_en;   // Peripheral drives the pin
        logic [7:0] out_val;  // Level it drives
        logic [7:0] out_od;   // Peripheral wants open-drain drive
    } gpx_alt_type;

    // Pad drive bundle
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } gpx_pad_type;

endpackage : gpx_pkg

// >>> gpx_port.sv
// Purpose: 8-pin general-purpose port with shared external interrupt vectors
// Assumes: Pads and peripheral inputs are asynchronous; CPU signals share ref_clk
// Notes:   Pin kind and vector grouping are fixed per instance by parameters
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module gpx_port #(
    parameter logic [7:0] INT_PULLUP_PINS = 8'h48,  // Interrupt pins with pull-up
    parameter logic [7:0] INT_FLOAT_PINS  = 8'ha0,  // Interrupt pins without pull-up
    parameter logic [7:0] VEC1_PINS       = 8'hc0   // Pins on vector 1, rest on vector 0
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // AXI4-Lite write address and data
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // AXI4-Lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // Pads
    input  wire logic [7:0]           pad_in,
    output gpx_pkg::gpx_pad_type      pad_drv,
    // On-chip peripherals sharing the pins
    input  wire gpx_pkg::gpx_alt_type alt_req,
    output logic [7:0]                alt_in_val,
    // CPU interrupt side
    input  wire logic                 cpu_int_mask,
    input  wire logic [1:0]           vec_fetch,
    output logic [1:0]                ext_irq,
    output logic                      wake_req
);

    // Reset release synchroniser
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Pad and peripheral inputs pass two flops; the first is read only by the second
    logic [7:0] pad_s1;
    logic [7:0] pad_lvl;
    logic [7:0] pad_prev;
    logic [7:0] alt_s1;
    logic [7:0] alt_en_s;
    logic [7:0] alt_v1;
    logic [7:0] alt_val_s;
    logic [7:0] alt_o1;
    logic [7:0] alt_od_s;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_s1    <= 8'h00;
            pad_lvl   <= 8'h00;
            pad_prev  <= 8'h00;
            alt_s1    <= 8'h00;
            alt_en_s  <= 8'h00;
            alt_v1    <= 8'h00;
            alt_val_s <= 8'h00;
            alt_o1    <= 8'h00;
            alt_od_s  <= 8'h00;
        end else begin
            pad_s1    <= pad_in;
            pad_lvl   <= pad_s1;
            pad_prev  <= pad_lvl;
            alt_s1    <= alt_req.out_en;
            alt_en_s  <= alt_s1;
            alt_v1    <= alt_req.out_val;
            alt_val_s <= alt_v1;
            alt_o1    <= alt_req.out_od;
            alt_od_s  <= alt_o1;
        end
    end

    // Software registers
    logic [7:0] pin_value_latch;
    logic [7:0] pin_direction;
    logic [7:0] pin_option_select;
    logic [3:0] ext_int_sensitivity_ctrl;
    logic [1:0] irq_req;

    // AXI write channel capture; address and data may come in either order
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic       w_lane0;

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_go    = aw_held && w_held && !s_axi_bvalid;
    wire wr_value = wr_go && w_lane0 && (aw_addr == gpx_pkg::OFF_VALUE);
    wire wr_dir   = wr_go && w_lane0 && (aw_addr == gpx_pkg::OFF_DIR);
    wire wr_opt   = wr_go && w_lane0 && (aw_addr == gpx_pkg::OFF_OPT);
    wire wr_sens  = wr_go && w_lane0 && (aw_addr == gpx_pkg::OFF_SENS);
    wire wr_map   = (aw_addr == gpx_pkg::OFF_VALUE) || (aw_addr == gpx_pkg::OFF_DIR)
                 || (aw_addr == gpx_pkg::OFF_OPT)   || (aw_addr == gpx_pkg::OFF_SENS);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !aw_take;
            s_axi_wready  <= !w_held && !w_take;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_held  <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gpx_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? gpx_pkg::RESP_OKAY : gpx_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A write to the value register only loads the latch; pin drive follows mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_value_latch          <= gpx_pkg::RST_VALUE;
            pin_direction            <= gpx_pkg::RST_DIR;
            pin_option_select        <= gpx_pkg::RST_OPT;
            ext_int_sensitivity_ctrl <= gpx_pkg::RST_SENS;
        end else begin
            if (wr_value) pin_value_latch <= w_byte;  // see RQ3
            if (wr_dir)   pin_direction <= w_byte;
            if (wr_opt)   pin_option_select <= w_byte;
            if (wr_sens)  ext_int_sensitivity_ctrl <= w_byte[3:0];
        end
    end

    // Per-pin mode decode, drive and interrupt qualification
    logic [7:0] read_val;
    logic [7:0] pin_evt_v0;
    logic [7:0] pin_evt_v1;
    logic [7:0] int_mode;
    gpx_pkg::gpx_pad_type next_pad;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            wire int_cap   = INT_PULLUP_PINS[gi] || INT_FLOAT_PINS[gi];
            wire on_vec1   = VEC1_PINS[gi];
            wire [1:0] sen = on_vec1 ? ext_int_sensitivity_ctrl[3:2] : ext_int_sensitivity_ctrl[1:0];
            wire rise      = pad_lvl[gi] && !pad_prev[gi];
            wire fall      = !pad_lvl[gi] && pad_prev[gi];
            wire hit       = (sen == gpx_pkg::SENS_LOW)  ? !pad_lvl[gi] :
                             (sen == gpx_pkg::SENS_RISE) ? rise :
                             (sen == gpx_pkg::SENS_FALL) ? fall : (rise || fall);
            // Option bit 01 in input is interrupt on capable pins; pull follows pin kind
            wire dir       = pin_direction[gi];  // see RQ1
            wire opt       = pin_option_select[gi];
            wire alt_out   = alt_en_s[gi];

            assign int_mode[gi]   = int_cap && !dir && opt;  // see RQ18, RQ23
            assign pin_evt_v0[gi] = int_mode[gi] && hit && !on_vec1;  // see RQ6
            assign pin_evt_v1[gi] = int_mode[gi] && hit && on_vec1;

            // Alternate output wins over software settings
            assign next_pad.oe[gi]   = alt_out ? (alt_od_s[gi] ? !alt_val_s[gi] : 1'b1)  // see RQ10, RQ11
                                     : (dir && (opt || !pin_value_latch[gi]));  // see RQ5, RQ17
            assign next_pad.out[gi]  = alt_out ? (alt_val_s[gi] && !alt_od_s[gi])
                                     : (dir && opt && pin_value_latch[gi]);
            assign next_pad.pull[gi] = !alt_out && !dir && opt && !INT_FLOAT_PINS[gi];  // see RQ17, RQ23

            // Read-back: latch in output, pin or peripheral output in input
            assign read_val[gi] = dir ? pin_value_latch[gi]  // see RQ4
                                : (alt_out ? alt_val_s[gi] : pad_lvl[gi]);  // see RQ2, RQ12, RQ13
        end
    endgenerate

    // Peripheral input sees the latch when the pin is an output
    wire [7:0] next_alt_in = (pin_direction & pin_value_latch) | (~pin_direction & pad_lvl);  // see RQ14

    // Vector request latches; an event in the clearing cycle still sets
    wire [1:0] vec_evt  = {|pin_evt_v1, |pin_evt_v0};  // see RQ7
    wire [1:0] sens_chg = wr_sens ? {w_byte[3:2] != ext_int_sensitivity_ctrl[3:2],
                                     w_byte[1:0] != ext_int_sensitivity_ctrl[1:0]} : 2'b00;
    wire [1:0] vec_clr  = vec_fetch | sens_chg;
    wire [1:0] next_req = vec_evt | (irq_req & ~vec_clr);  // see RQ8, RQ9, RQ24

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req    <= 2'b00;
            ext_irq    <= 2'b00;
            wake_req   <= 1'b0;
            pad_drv    <= '0;
            alt_in_val <= 8'h00;
        end else begin
            irq_req    <= next_req;
            ext_irq    <= next_req & {2{!cpu_int_mask}};  // see RQ15
            wake_req   <= |next_req;  // see RQ16
            pad_drv    <= next_pad;
            alt_in_val <= next_alt_in;
        end
    end

    // AXI read; status word shows pad level, interrupt modes and drive state
    wire        ar_take  = s_axi_arvalid && s_axi_arready;
    wire [7:0]  ar_word  = {s_axi_araddr[7:2], 2'b00};
    wire        rd_map   = (ar_word <= gpx_pkg::OFF_STAT);
    wire [31:0] rd_mux   = (ar_word == gpx_pkg::OFF_VALUE) ? {24'h000000, read_val} :
                           (ar_word == gpx_pkg::OFF_DIR)   ? {24'h000000, pin_direction} :
                           (ar_word == gpx_pkg::OFF_OPT)   ? {24'h000000, pin_option_select} :
                           (ar_word == gpx_pkg::OFF_SENS)  ? {28'h0000000, ext_int_sensitivity_ctrl} :
                           (ar_word == gpx_pkg::OFF_STAT)  ? {8'h00, pad_drv.oe, int_mode, pad_lvl} : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= gpx_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_map ? gpx_pkg::RESP_OKAY : gpx_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= s_axi_rready;
            s_axi_rvalid  <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    a_evt_sets_req: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ24
        (vec_evt[0]) |=> irq_req[0] ##1 (irq_req[0] || $past(vec_clr[0])))
        else $error("vector 0 request not held after event");

    a_fetch_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ8
        (vec_fetch[1] && !vec_evt[1]) |=> !irq_req[1] && !ext_irq[1])
        else $error("vector fetch did not clear request");

    a_sens_discards: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ9
        (sens_chg[0] && !vec_evt[0]) |=> !irq_req[0])
        else $error("sensitivity rewrite kept request");

    a_mask_gates: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ15
        ext_irq != 2'b00 |-> !$past(cpu_int_mask) && (ext_irq == irq_req))
        else $error("interrupt raised while masked");

    a_no_int_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ6
        (int_mode == 8'h00 && irq_req == 2'b00) |=> irq_req == 2'b00)
        else $error("request without interrupt input mode");

    a_wake_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ16
        wake_req == (irq_req != 2'b00))
        else $error("wake does not follow requests");

    generate
        for (gi = 0; gi < 8; gi++) begin : g_chk
            a_input_float: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ3
                (!pin_direction[gi] && !alt_en_s[gi]) |=> !pad_drv.oe[gi])
                else $error("input pin is driven");

            a_od_release: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ5
                (pin_direction[gi] && !pin_option_select[gi] && !alt_en_s[gi])
                |=> pad_drv.oe[gi] == !$past(pin_value_latch[gi]) && !pad_drv.out[gi])
                else $error("open-drain drive wrong");

            a_alt_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ10
                (alt_en_s[gi] && !alt_od_s[gi]) |=> pad_drv.oe[gi] && pad_drv.out[gi] == $past(alt_val_s[gi]))
                else $error("peripheral output not on pin");

            a_read_source: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ2
                (ar_take && ar_word == gpx_pkg::OFF_VALUE)
                |=> s_axi_rdata[gi] == ($past(pin_direction[gi]) ? $past(pin_value_latch[gi])
                    : $past(alt_en_s[gi]) ? $past(alt_val_s[gi]) : $past(pad_lvl[gi])))
                else $error("value read from wrong source");
        end
    endgenerate

endmodule : gpx_port

// >>> gpx_pin_model.sv
// Purpose: Pin-side partner: external sources, pull-ups and floating pads
// Assumes: Port drive wins any contention with the external source
// Notes:   Undriven pins without pull-up toggle every cycle
`timescale 1ns/1ps

module gpx_pin_model (
    // Clock
    input  wire logic                 ref_clk,
    // Port drive and external source
    input  wire gpx_pkg::gpx_pad_type pad_drv,
    input  wire logic [7:0]           ext_en,
    input  wire logic [7:0]           ext_val,
    // Resolved pin levels
    output logic [7:0]                pad_in
);
    logic [7:0] float_pat = 8'h55;
    logic [7:0] idle;

    // A released pin must never look as if it kept its last level
    always @(posedge ref_clk) begin
        float_pat <= ~float_pat;
    end
    assign idle   = ~pad_drv.oe & ~ext_en;
    assign pad_in = (pad_drv.oe & pad_drv.out) | (~pad_drv.oe & ext_en & ext_val)
                  | (idle & pad_drv.pull) | (idle & ~pad_drv.pull & float_pat);
endmodule : gpx_pin_model

// >>> test_gpio_port_with_ext_interrupts.sv
// Purpose: Self-checking bench for the I/O port with external interrupts
// Assumes: Default pin grouping parameters of the port
// Notes:   Register table rows first, then pin, peripheral and interrupt cases
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module test_gpio_port_with_ext_interrupts;
    typedef struct packed {
        logic [7:0]  a;
        logic [3:0]  s;
        logic [31:0] d;
        logic [1:0]  wr;
        logic [31:0] q;
        logic [1:0]  rr;
    } gpx_row_type;

    logic ref_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_int_mask, wake_req;
    logic [7:0]           s_axi_awaddr, s_axi_araddr, pad_in, alt_in_val, ext_en, ext_val;
    logic [31:0]          s_axi_wdata, s_axi_rdata;
    logic [3:0]           s_axi_wstrb;
    logic [1:0]           s_axi_bresp, s_axi_rresp, vec_fetch, ext_irq;
    gpx_pkg::gpx_pad_type pad_drv;
    gpx_pkg::gpx_alt_type alt_req;
    int                   fail_count = 0;
    int                   n_checks = 0;
    // Wrong strobe and unmapped places sit between ordinary accesses
    gpx_row_type rows [6] = '{
        '{gpx_pkg::OFF_DIR, 4'hf, 32'ha5, 2'h0, 32'ha5, 2'h0},
        '{gpx_pkg::OFF_DIR, 4'he, 32'hff, 2'h0, 32'ha5, 2'h0},
        '{gpx_pkg::OFF_OPT, 4'hf, 32'h3c, 2'h0, 32'h3c, 2'h0},
        '{gpx_pkg::OFF_SENS, 4'hf, 32'hff, 2'h0, 32'h0f, 2'h0},
        '{8'h14, 4'hf, 32'h01, 2'h2, 32'h00, 2'h2},
        '{gpx_pkg::OFF_DIR, 4'hf, 32'h00, 2'h0, 32'h00, 2'h0}};

    gpx_port dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .pad_in(pad_in), .pad_drv(pad_drv), .alt_req(alt_req), .alt_in_val(alt_in_val),
        .cpu_int_mask(cpu_int_mask), .vec_fetch(vec_fetch), .ext_irq(ext_irq), .wake_req(wake_req));
    gpx_pin_model pins_u (.ref_clk(ref_clk), .pad_drv(pad_drv), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_n

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        r = 2'h1;
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_bready  <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        fail_count++;
        $display("BAD %0t write got no answer", $time);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic a_ok = 1'b0;
        r = 2'h1;
        d = 32'h0;
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (!a_ok && s_axi_arready === 1'b1) begin
                a_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        fail_count++;
        $display("BAD %0t read got no answer", $time);
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hf, r);
        `CHK(r, gpx_pkg::RESP_OKAY)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [1:0]  r;
        logic [31:0] d;
        axi_rd(a, d, r);
        `CHK(d, e)
        `CHK(r, gpx_pkg::RESP_OKAY)
    endtask : rd

    // Requests need a few cycles through the pad synchronisers
    task automatic wait_irq(input int v);
        for (int i = 0; i < 20 && ext_irq[v] !== 1'b1; i++) @(posedge ref_clk);
        `CHK(ext_irq[v], 1'b1)
    endtask : wait_irq

    task automatic pulse_fetch(input logic [1:0] v);
        vec_fetch <= v;
        @(posedge ref_clk);
        vec_fetch <= 2'h0;
        wait_n(3);
    endtask : pulse_fetch

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        wait_n(3000);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        logic [1:0]  r;
        logic [31:0] q;
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cpu_int_mask, vec_fetch} = '0;
        alt_req = '0;
        ext_en  = 8'hff;
        ext_val = 8'h00;
        wait_n(5);
        arst_n <= 1'b1;
        wait_n(4);
        `CHK(pad_drv, 24'h0)
        rd(gpx_pkg::OFF_VALUE, {24'h0, gpx_pkg::RST_VALUE});
        rd(gpx_pkg::OFF_OPT, {24'h0, gpx_pkg::RST_OPT});
        foreach (rows[i]) begin
            axi_wr(rows[i].a, rows[i].d, rows[i].s, r);
            `CHK(r, rows[i].wr)
            axi_rd(rows[i].a, q, r);
            `CHK(q, rows[i].q)
            `CHK(r, rows[i].rr)
        end
        // Outputs: latch read back even where the pin disagrees
        ext_val <= 8'h3c;
        wr(gpx_pkg::OFF_VALUE, 32'ha5);
        wr(gpx_pkg::OFF_DIR, 32'hff);
        wr(gpx_pkg::OFF_OPT, 32'hff);
        wait_n(2);
        `CHK(pad_drv.oe, 8'hff)
        `CHK(pad_drv.out, 8'ha5)
        wr(gpx_pkg::OFF_OPT, 32'h00);
        wait_n(4);
        `CHK(pad_drv.oe, 8'h5a)
        `CHK(pad_drv.out & pad_drv.oe, 8'h00)
        rd(gpx_pkg::OFF_VALUE, 32'ha5);
        wr(gpx_pkg::OFF_DIR, 32'h0f);
        wait_n(4);
        `CHK(pad_drv.oe, 8'h0a)
        rd(gpx_pkg::OFF_VALUE, 32'h35);
        wr(gpx_pkg::OFF_DIR, 32'h00);
        wr(gpx_pkg::OFF_VALUE, 32'hff);
        wait_n(2);
        `CHK(pad_drv.oe, 8'h00)
        rd(gpx_pkg::OFF_VALUE, 32'h3c);
        wr(gpx_pkg::OFF_OPT, 32'hff);
        wait_n(6);
        `CHK(pad_drv.pull, ~8'ha0)
        // Vector 0 is still pending from the low-level rows; pin 6 rises on vector 1
        ext_val <= 8'h7c;
        wait_n(5);
        `CHK(ext_irq, 2'b11)
        wr(gpx_pkg::OFF_OPT, 32'h00);
        ext_val <= 8'h3c;
        wr(gpx_pkg::OFF_SENS, 32'h0a);
        wait_n(2);
        `CHK(ext_irq, 2'b00)
        // Peripheral takes over pin 0
        alt_req <= '{out_en: 8'h01, out_val: 8'h01, out_od: 8'h00};
        wait_n(4);
        `CHK(pad_drv.oe, 8'h01)
        rd(gpx_pkg::OFF_VALUE, 32'h3d);
        alt_req.out_od <= 8'h01;
        wait_n(4);
        `CHK(pad_drv.oe, 8'h00)
        rd(gpx_pkg::OFF_VALUE, 32'h3d);
        `CHK(alt_in_val, 8'h3c)
        alt_req <= '0;
        wr(gpx_pkg::OFF_VALUE, 32'h5a);
        wr(gpx_pkg::OFF_DIR, 32'hff);
        wait_n(4);
        `CHK(alt_in_val, 8'h5a)
        wr(gpx_pkg::OFF_DIR, 32'h00);
        // Interrupts on vectors 0 and 1, falling edge
        ext_val <= 8'hff;
        wr(gpx_pkg::OFF_OPT, 32'h08);
        rd(gpx_pkg::OFF_STAT, 32'h0008ff);
        ext_val <= 8'hf7;
        wait_irq(0);
        ext_val <= 8'hff;
        wait_n(5);
        `CHK(ext_irq, 2'b01)
        cpu_int_mask <= 1'b1;
        wait_n(3);
        `CHK(ext_irq, 2'b00)
        `CHK(wake_req, 1'b1)
        cpu_int_mask <= 1'b0;
        pulse_fetch(2'b01);
        `CHK({ext_irq, wake_req}, 3'b000)
        ext_val <= 8'hf7;
        wait_irq(0);
        wr(gpx_pkg::OFF_SENS, 32'h0a);
        wait_n(2);
        `CHK(ext_irq, 2'b01)
        wr(gpx_pkg::OFF_SENS, 32'h09);
        wait_n(2);
        `CHK(ext_irq, 2'b00)
        wr(gpx_pkg::OFF_OPT, 32'h01);
        ext_val <= 8'hfe;
        wait_n(10);
        `CHK(ext_irq, 2'b00)
        wr(gpx_pkg::OFF_OPT, 32'h80);
        ext_val <= 8'h7e;
        wait_irq(1);
        `CHK(ext_irq[0], 1'b0)
        pulse_fetch(2'b10);
        `CHK(ext_irq, 2'b00)
        // Mid-run reset must bring the registers back
        arst_n <= 1'b0;
        wait_n(2);
        arst_n <= 1'b1;
        wait_n(4);
        `CHK({ext_irq, wake_req}, 3'b000)
        rd(gpx_pkg::OFF_OPT, {24'h0, gpx_pkg::RST_OPT});
        tally_and_finish;
    end
endmodule : test_gpio_port_with_ext_interrupts
